// ### hdl/blu_regs.svh
// Constants for the bitblt logic unit and queue
`ifndef BLU_REGS_SVH
`define BLU_REGS_SVH
`define BLU_WORD_W      16
`define BLU_DEPTH       16
`define BLU_PA_W        4
`define BLU_FN_W        4
`define BLU_SLOT0       16'h0001
`define BLU_WORD_ZERO   16'h0000
`define BLU_WORD_ONES   16'hFFFF
`define BLU_PA_MAX      4'hF
`define BLU_FN_SD       3
`define BLU_FN_SND      2
`define BLU_FN_NSD      1
`define BLU_FN_NSND     0
`endif

// ### hdl/blu_pkg.sv
// Types shared by the bitblt logic unit files
package blu_pkg;
    typedef logic [15:0] blu_word_t;
    typedef enum logic {BLU_MODE_BLIT, BLU_MODE_LINE} blu_mode_t;
endpackage : blu_pkg

// ### hdl/blu_logic_unit.sv
// Combinational sixteen-function logic unit with destination masking
`timescale 1ns/1ps
`include "blu_regs.svh"
module blu_logic_unit (
    input  wire logic [`BLU_FN_W-1:0]   logic_function_code,
    input  wire blu_pkg::blu_word_t     src,
    input  wire blu_pkg::blu_word_t     dst,
    input  wire blu_pkg::blu_word_t     mask,
    output wire blu_pkg::blu_word_t     result
);
    genvar i;
    generate
        for (i = 0; i < `BLU_WORD_W; i = i + 1) begin : g_bit
            logic f;
            // All bits evaluated in parallel with one function code
            assign f = (logic_function_code[`BLU_FN_SD]   &  src[i] &  dst[i]) |
                       (logic_function_code[`BLU_FN_SND]  &  src[i] & ~dst[i]) |
                       (logic_function_code[`BLU_FN_NSD]  & ~src[i] &  dst[i]) |
                       (logic_function_code[`BLU_FN_NSND] & ~src[i] & ~dst[i]);
            // Zero mask bit keeps destination
            assign result[i] = mask[i] ? f : dst[i];
        end
    endgenerate
endmodule : blu_logic_unit

// ### hdl/blu_datapath.sv
// Logic unit, line-drawing path and sixteen-word queue for one bitplane
`timescale 1ns/1ps
`include "blu_regs.svh"
// Summary of operation
// - Result is OR of four gated minterms
// - Zero mask bit keeps destination bit
// - Select high means line mode, low blit
// - Line mode bypasses queue for logic
// - Line mode ignores shift and mask indices
// - Line mode masks open one addressed bit
// - Pixel p maps to word bit fifteen minus p
// - Pixel latch bit replicated across source
// - Pixel output driven in line mode only
// - Sixteen words, independent read and write ports
// - One-hot ring counters advance on strobes
// - Reset selects location zero for both
// - Counters wrap fifteen to zero, never block
// - Write stores shifter or logic result
// - Read-ahead latch, output updates on read
// - Same-slot read gives old contents
// - Reads and writes every cycle sustained
// - New operand accepted every cycle
module blu_datapath #(
    parameter int WIDTH = `BLU_WORD_W,
    parameter int DEPTH = `BLU_DEPTH
) (
    input  wire logic                   clk,
    input  wire logic                   rst_b,
    input  wire logic                   line_mode_sel,
    input  wire logic [`BLU_FN_W-1:0]   logic_function_code,
    input  wire logic [`BLU_PA_W-1:0]   pixel_bit_address,
    input  wire logic [`BLU_PA_W-1:0]   left_mask_index,
    input  wire logic [`BLU_PA_W-1:0]   right_mask_index,
    input  wire logic [WIDTH-1:0]       blit_mask,
    input  wire logic [WIDTH-1:0]       shifter_word,
    input  wire logic [WIDTH-1:0]       dest_word,
    input  wire logic                   dest_load,
    input  wire logic                   pixel_bit_port_in,
    input  wire logic                   pixel_load,
    input  wire logic                   source_path_enable,
    input  wire logic                   queue_write_strobe,
    input  wire logic                   queue_read_strobe,
    output logic [WIDTH-1:0]            result_word,
    output logic [WIDTH-1:0]            queue_word,
    output logic                        pixel_result_out,
    output logic                        pixel_result_oe_b
);
    // ========================================================================
    // State
    // ========================================================================
    logic [WIDTH-1:0] mem_reg [DEPTH];
    logic [WIDTH-1:0] mem_next [DEPTH];
    logic [DEPTH-1:0] wr_sel_reg, wr_sel_next;
    logic [DEPTH-1:0] rd_sel_reg, rd_sel_next;
    logic [WIDTH-1:0] ahead_reg, ahead_next;
    logic [WIDTH-1:0] queue_word_reg, queue_word_next;
    logic [WIDTH-1:0] dest_reg, dest_next;
    logic             pixel_input_latch_reg, pixel_input_latch_next;
    logic [WIDTH-1:0] result_reg, result_next;
    logic             pix_reg, pix_next;
    logic             pix_oe_b_reg, pix_oe_b_next;
    blu_pkg::blu_mode_t mode;
    logic [WIDTH-1:0] src_op, mask_op, lu_out, line_mask, left_m, right_m;
    logic [WIDTH-1:0] rd_word;
    logic [`BLU_PA_W-1:0] phys_bit;

    // ========================================================================
    // Line-drawing operand selection
    // ========================================================================
    always_comb begin
        mode = line_mode_sel ? blu_pkg::BLU_MODE_LINE : blu_pkg::BLU_MODE_BLIT;
        // Ones-complement maps pixel zero to the top data bit
        phys_bit = `BLU_PA_MAX - pixel_bit_address;
        // Matched pair: left opens bits at and below, right at and above
        left_m  = WIDTH'(`BLU_WORD_ONES) >> pixel_bit_address;
        right_m = ~(WIDTH'(`BLU_WORD_ONES) >> pixel_bit_address) | ({WIDTH{1'b0}} |
                  (WIDTH'(1) << phys_bit));
        line_mask = left_m & right_m;
        // Shift and mask indices have no effect in line mode
        if (mode == blu_pkg::BLU_MODE_LINE) begin
            src_op  = {WIDTH{pixel_input_latch_reg}};
            mask_op = line_mask;
        end else begin
            src_op  = queue_word_reg;
            mask_op = blit_mask;
        end
    end

    blu_logic_unit u_lu (
        .logic_function_code (logic_function_code),
        .src                 (src_op),
        .dst                 (dest_reg),
        .mask                (mask_op),
        .result              (lu_out)
    );

    // ========================================================================
    // Queue read mux
    // ========================================================================
    always_comb begin
        // Look at the slot selected after this edge, so back-to-back reads advance
        rd_word = '0;
        for (int k = 0; k < DEPTH; k++) begin
            if (rd_sel_next[k]) begin
                rd_word = rd_word | mem_reg[k];
            end
        end
    end

    // ========================================================================
    // Next state
    // ========================================================================
    always_comb begin
        for (int k = 0; k < DEPTH; k++) begin
            // Write port independent of read port
            mem_next[k] = (queue_write_strobe && wr_sel_reg[k]) ?
                          (source_path_enable ? shifter_word : result_reg) : mem_reg[k];
        end
        // Rotate left wraps top slot to slot zero, no full/empty blocking
        wr_sel_next = queue_write_strobe ?
                      {wr_sel_reg[DEPTH-2:0], wr_sel_reg[DEPTH-1]} : wr_sel_reg;
        rd_sel_next = queue_read_strobe ?
                      {rd_sel_reg[DEPTH-2:0], rd_sel_reg[DEPTH-1]} : rd_sel_reg;
        // Read-ahead copies stored word every cycle; same-slot write not seen
        ahead_next = rd_word;
        // Output word only moves on read strobe, both strobes every cycle ok
        queue_word_next = queue_read_strobe ? ahead_reg : queue_word_reg;
        dest_next = dest_load ? dest_word : dest_reg;
        pixel_input_latch_next = pixel_load ? pixel_bit_port_in : pixel_input_latch_reg;
        result_next = lu_out;
        pix_next = lu_out[phys_bit];
        // Enable low only while drawing lines
        pix_oe_b_next = (mode != blu_pkg::BLU_MODE_LINE);
    end

    // ========================================================================
    // Registers
    // ========================================================================
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            wr_sel_reg            <= DEPTH'(`BLU_SLOT0);
            rd_sel_reg            <= DEPTH'(`BLU_SLOT0);
            ahead_reg             <= `BLU_WORD_ZERO;
            queue_word_reg        <= `BLU_WORD_ZERO;
            dest_reg              <= `BLU_WORD_ZERO;
            pixel_input_latch_reg <= 1'b0;
            result_reg            <= `BLU_WORD_ZERO;
            pix_reg               <= 1'b0;
            pix_oe_b_reg          <= 1'b1;
        end else begin
            wr_sel_reg            <= wr_sel_next;
            rd_sel_reg            <= rd_sel_next;
            ahead_reg             <= ahead_next;
            queue_word_reg        <= queue_word_next;
            dest_reg              <= dest_next;
            pixel_input_latch_reg <= pixel_input_latch_next;
            result_reg            <= result_next;
            pix_reg               <= pix_next;
            pix_oe_b_reg          <= pix_oe_b_next;
        end
    end

    // Storage has no reset; contents are undefined until written
    always_ff @(posedge clk) begin
        for (int k = 0; k < DEPTH; k++) begin
            mem_reg[k] <= mem_next[k];
        end
    end

    assign result_word       = result_reg;
    assign queue_word        = queue_word_reg;
    assign pixel_result_out  = pix_reg;
    assign pixel_result_oe_b = pix_oe_b_reg;
endmodule : blu_datapath

// ### tb/blu_mem_model.sv
// Frame memory model feeding source words to the datapath
`timescale 1ns/1ps
module blu_mem_model (
    input  logic [7:0]  addr,
    output logic [15:0] word
);
    // Zero-wait read, so a new operand is ready every clock
    assign word = {addr, ~addr};
endmodule : blu_mem_model

// ### tb/blu_datapath_asserts.sv
// Port-level assertions for the bitblt datapath
`timescale 1ns/1ps
module blu_datapath_asserts #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 16
) (
    input logic             clk,
    input logic             rst_b,
    input logic             line_mode_sel,
    input logic [3:0]       logic_function_code,
    input logic [3:0]       pixel_bit_address,
    input logic [WIDTH-1:0] blit_mask,
    input logic [WIDTH-1:0] dest_word,
    input logic             dest_load,
    input logic             pixel_bit_port_in,
    input logic             pixel_load,
    input logic             queue_read_strobe,
    input logic [WIDTH-1:0] result_word,
    input logic [WIDTH-1:0] queue_word,
    input logic             pixel_result_out,
    input logic             pixel_result_oe_b
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_b);
    // Destination loaded, then one cycle with the latch holding it
    sequence s_dl(logic m);
        (line_mode_sel == m && dest_load) ##1 (line_mode_sel == m && !dest_load);
    endsequence
    sequence s_px;
        (line_mode_sel && pixel_load) ##1 (line_mode_sel && logic_function_code == 4'hC);
    endsequence
    property p_rst; $rose(rst_b) |-> !result_word && !queue_word && pixel_result_oe_b; endproperty
    a_rst: assert property (p_rst) else $error("reset values");
    property p_oe; 1'h1 |=> pixel_result_oe_b == !$past(line_mode_sel); endproperty
    a_oe: assert property (p_oe) else $error("pixel enable");
    property p_hold; !queue_read_strobe |=> $stable(queue_word); endproperty
    a_hold: assert property (p_hold) else $error("queue output moved");
    property p_src;
        !line_mode_sel && logic_function_code == 4'hC
            |=> ((result_word ^ $past(queue_word)) & $past(blit_mask)) == '0;
    endproperty
    a_src: assert property (p_src) else $error("blit source");
    property p_bkeep; s_dl(1'h0) |=> !((result_word ^ $past(dest_word, 2)) & ~$past(blit_mask));
    endproperty
    a_bkeep: assert property (p_bkeep) else $error("blit mask");
    property p_lkeep;
        s_dl(1'h1) |=> !((result_word ^ $past(dest_word, 2))
            & ~(16'h8000 >> $past(pixel_bit_address)));
    endproperty
    a_lkeep: assert property (p_lkeep) else $error("line mask");
    property p_rep;
        s_px |=> result_word[4'hF - $past(pixel_bit_address)] == $past(pixel_bit_port_in, 2);
    endproperty
    a_rep: assert property (p_rep) else $error("pixel source");
    property p_pout;
        line_mode_sel |=> pixel_result_out == result_word[4'hF - $past(pixel_bit_address)];
    endproperty
    a_pout: assert property (p_pout) else $error("pixel output");
endmodule : blu_datapath_asserts
bind blu_datapath blu_datapath_asserts #(.WIDTH(WIDTH), .DEPTH(DEPTH)) chk_u (.clk, .rst_b,
    .line_mode_sel, .logic_function_code, .pixel_bit_address, .blit_mask, .dest_word, .dest_load,
    .pixel_bit_port_in, .pixel_load, .queue_read_strobe, .result_word, .queue_word,
    .pixel_result_out, .pixel_result_oe_b);

// ### tb/blu_datapath_tb.sv
// Bench for the bitblt datapath: queue, blit functions, line drawing
`timescale 1ns/1ps
module blu_datapath_tb;
    logic        clk = 1'h0, rst_b = 1'h0, line_mode_sel = 1'h0, dest_load = 1'h0;
    logic        pixel_bit_port_in = 1'h1, pixel_load = 1'h0, source_path_enable = 1'h0;
    logic        queue_write_strobe = 1'h0, queue_read_strobe = 1'h0;
    logic        pixel_result_out, pixel_result_oe_b;
    logic [3:0]  logic_function_code = 4'h0, pixel_bit_address = 4'h0;
    logic [3:0]  left_mask_index = 4'h7, right_mask_index = 4'h3;
    logic [7:0]  mem_addr = 8'h00;
    logic [15:0] blit_mask = 16'h0FF0, dest_word = 16'h3C5A;
    logic [15:0] shifter_word, result_word, queue_word;
    int          err_count = 0, comparisons = 0;
    always #25 clk = ~clk;
    blu_datapath dut_u (.clk, .rst_b, .line_mode_sel, .logic_function_code, .pixel_bit_address,
        .left_mask_index, .right_mask_index, .blit_mask, .shifter_word, .dest_word, .dest_load,
        .pixel_bit_port_in, .pixel_load, .source_path_enable, .queue_write_strobe,
        .queue_read_strobe, .result_word, .queue_word, .pixel_result_out, .pixel_result_oe_b);
    blu_mem_model mem_u (.addr(mem_addr), .word(shifter_word));
    function automatic logic [15:0] mw(input logic [7:0] a);
        return {a, ~a};
    endfunction : mw
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        comparisons++;
        if (got !== exp) begin
            err_count++;
            $display("unexpected at %0t: got %h, want %h", $time, got, exp);
        end
    endtask : chk
    // Shifted word queued the cycle after it is fetched
    task automatic t_queue;
        @(posedge clk);
        source_path_enable <= 1'h1;
        queue_write_strobe <= 1'h1;
        for (int i = 1; i <= 16; i++) begin
            @(posedge clk);
            mem_addr <= 8'(i);
            queue_write_strobe <= (i < 16);
            queue_read_strobe <= (i == 16);
        end
        // Each slot is read at least two cycles after it was written
        for (int i = 0; i < 16; i++) begin
            @(posedge clk);
            queue_write_strobe <= (i == 15);
            #1 chk(queue_word, mw(8'(i)));
        end
        @(posedge clk);
        queue_write_strobe <= 1'h0;
        queue_read_strobe <= 1'h0;
        #1 chk(queue_word, mw(8'h00));
    endtask : t_queue
    task automatic t_logic;
        logic [15:0] s, r;
        s = 16'h00FF;
        @(posedge clk);
        dest_load <= 1'h1;
        for (int f = 0; f < 16; f++) begin
            @(posedge clk);
            dest_load <= 1'h0;
            logic_function_code <= 4'(f);
            @(posedge clk);
            r = ({16{f[3]}} & s & dest_word) | ({16{f[2]}} & s & ~dest_word);
            r = r | ({16{f[1]}} & ~s & dest_word) | ({16{f[0]}} & ~s & ~dest_word);
            #1 chk(result_word, (r & blit_mask) | (dest_word & ~blit_mask));
        end
        // Queue the logic result instead of the shifter word, read it back two cycles later
        @(posedge clk);
        source_path_enable <= 1'h0;
        queue_write_strobe <= 1'h1;
        @(posedge clk);
        queue_write_strobe <= 1'h0;
        @(posedge clk);
        queue_read_strobe <= 1'h1;
        @(posedge clk);
        queue_read_strobe <= 1'h0;
        #1 chk(queue_word, blit_mask | (dest_word & ~blit_mask));
        chk(pixel_result_oe_b, 1'h1);
    endtask : t_logic
    task automatic t_line;
        logic [15:0] m, p;
        @(posedge clk);
        line_mode_sel <= 1'h1;
        dest_load <= 1'h1;
        pixel_load <= 1'h1;
        queue_read_strobe <= 1'h1;
        logic_function_code <= 4'hC;
        for (int k = 0; k < 4; k++) begin
            @(posedge clk);
            dest_load <= 1'h0;
            pixel_bit_address <= 4'(k * 5);
            pixel_bit_port_in <= k[0];
            left_mask_index <= 4'(k);
            right_mask_index <= 4'(15 - k);
            @(posedge clk);
            // Pixel latch in use now was loaded from the previous pass
            m = 16'h8000 >> (k * 5);
            p = k[0] ? 16'h0000 : 16'h0002;
            #1 chk(result_word, (dest_word & ~m) | (m & {16{~k[0]}}));
            chk({pixel_result_out, pixel_result_oe_b}, p);
        end
    endtask : t_line
    task automatic final_report;
        $display("errors %0d, comparisons %0d", err_count, comparisons);
        if (err_count == 0 && comparisons > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : final_report
    initial begin
        repeat (5) @(posedge clk);
        rst_b <= 1'h1;
        t_queue();
        t_logic();
        t_line();
        final_report();
    end
endmodule : blu_datapath_tb
